// ===== logic/ssr_pkg.sv
// constants for the standby and reset controller
`default_nettype none
package ssr_pkg;
  // register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // register offsets (word index on the plain port)
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_IRQ_STAT = 3'h2;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h3;
  localparam logic [2:0] OFS_COUNT = 3'h4;
  // control register fields
  localparam int CTRL_CS1 = 0;
  localparam int CTRL_CS2 = 1;
  localparam int CTRL_SM1 = 2;
  localparam int CTRL_SM2 = 3;
  localparam int CTRL_SM3 = 4;
  // status register fields
  localparam int STAT_MODE_LO = 0;
  localparam int STAT_MODE_HI = 1;
  localparam int STAT_TFLAG = 2;
  localparam int STAT_SFLAG = 3;
  // interrupt event bits
  localparam int IRQ_W = 3;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_OVF = 2;
  // reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  localparam logic [9:0] START_ADDR = 10'h000;
  // clock select encodings {bit2, bit1}
  localparam logic [1:0] CS_DIV256 = 2'h0;
  localparam logic [1:0] CS_DIV32 = 2'h1;
  localparam logic [1:0] CS_DIV4 = 2'h2;
  localparam logic [1:0] CS_PIN = 2'h3;
  // prescaler tap masks for each divided rate
  localparam logic [7:0] TAP_256 = 8'hFF;
  localparam logic [7:0] TAP_32 = 8'h1F;
  localparam logic [7:0] TAP_4 = 8'h03;
  // operating modes
  typedef enum logic [1:0] {MODE_RUN, MODE_HALT, MODE_STOP} ssr_mode_t;
endpackage
`default_nettype wire

// ===== logic/ssr_standby_reset.sv
// standby and reset controller: clock gating, wake-up, reset init
//
// Functional notes
// - halt stops divider only; oscillator keeps running
// - halt keeps timer count pulses from selected source
// - either request flag ends standby; resume next
// - flag wake-up keeps all registers and memory
// - reset ends standby; held until release
// - after reset fetch starts at address zero
// - reset wake keeps memory; others undefined
// - high reset level is active; full initialisation
// - reset clears all ten program counter bits
// - reset clears both skip flags
// - reset clears timer count register
// - reset clears clock select and prescalers
// - reset clears shift mode bits
// - reset clears both request flags
// - memory, stack, accumulator etc left uninitialised
// - reset floats all port buffers, inputs
// - standby refused while any request flag set
// - stop halts oscillator and divider both
//
// Implementation choices: the strobed register port and the address map.
`default_nettype none
module ssr_standby_reset #(
  parameter int NUM_PORTS = 4
) (
  // clock and reset (rst is the device reset input)
  input wire logic clk,
  input wire logic rst,
  // requests from the instruction decoder, one-cycle pulses
  input wire logic stop_req,
  input wire logic halt_req,
  input wire logic skip_test_timer,
  input wire logic skip_test_shared,
  input wire logic timer_restart,
  input wire logic serial_start,
  // events from the serial unit and the count pin
  input wire logic serial_done_event,
  input wire logic external_count_pin,
  // port drive requests from the core
  input wire logic [NUM_PORTS-1:0] port_drive_req,
  // register port
  input wire logic [ssr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ssr_pkg::DATA_W-1:0] reg_rdata,
  // clock enables toward the core
  output logic osc_clk_en_q,
  output logic cpu_clk_en_q,
  output logic timer_count_pulse_q,
  // core control
  output logic core_init_q,
  output logic [9:0] start_addr_q,
  output logic resume_q,
  output logic standby_q,
  // flags and modes seen by the core
  output logic timer_overflow_flag_q,
  output logic shared_event_flag_q,
  output logic [7:0] count_q,
  output logic clock_select_bit2_q,
  output logic clock_select_bit1_q,
  output logic shift_mode_bit2_q,
  output logic shift_mode_bit1_q,
  output logic event_source_select_q,
  // port buffers, enable low means driving
  output logic [NUM_PORTS-1:0] port_oe_n_q,
  // interrupt
  output logic irq_q
);

  // parameter sanity, refused at elaboration rather than at run time
  if (NUM_PORTS < 1 || NUM_PORTS > 16)
  begin : g_bad_ports
    $error("ssr_standby_reset: NUM_PORTS out of range");
  end

  // operating mode state
  ssr_pkg::ssr_mode_t mode_q;
  // divide-by-two phase for the cpu clock
  logic div2_q;
  // shared prescaler chain
  logic [7:0] presc_q;
  // pin synchroniser and edge history
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  // interrupt status and mask
  logic [ssr_pkg::IRQ_W-1:0] irq_stat_q;
  logic [ssr_pkg::IRQ_W-1:0] irq_mask_q;
  // combinational helpers
  logic osc_run;
  logic pin_rise;
  logic any_flag;
  logic standby_entry;
  logic entry_refused;
  logic wake;
  logic cl_tick;
  logic count_tick;
  logic overflow;
  logic shared_set;
  logic shared_clr;
  logic timer_clr;
  logic ctrl_wr;
  logic stat_rd;
  logic [1:0] clk_sel;
  logic [ssr_pkg::IRQ_W-1:0] irq_events;

  // oscillator runs unless stop mode holds it
  assign osc_run = (mode_q != ssr_pkg::MODE_STOP);
  assign any_flag = timer_overflow_flag_q | shared_event_flag_q;
  assign standby_entry = (stop_req | halt_req) && mode_q == ssr_pkg::MODE_RUN;
  // entry is refused while a flag is pending, else it would wake at once
  assign entry_refused = standby_entry & any_flag;
  assign wake = (mode_q != ssr_pkg::MODE_RUN) & any_flag;
  assign pin_rise = pin_sync_q & ~pin_prev_q;
  assign clk_sel = {clock_select_bit2_q, clock_select_bit1_q};
  assign ctrl_wr = reg_wr && reg_addr == ssr_pkg::OFS_CTRL;
  assign stat_rd = reg_rd && reg_addr == ssr_pkg::OFS_IRQ_STAT;

  // oscillator tick: clk is the oscillator, idle only in stop
  assign cl_tick = osc_run;

  // count pulse source selection, pin path works even in stop
  always_comb
  begin
    case (clk_sel)
      ssr_pkg::CS_DIV256:
        count_tick = cl_tick && presc_q == ssr_pkg::TAP_256;
      ssr_pkg::CS_DIV32:
        count_tick = cl_tick && (presc_q & ssr_pkg::TAP_32) ==
          ssr_pkg::TAP_32;
      ssr_pkg::CS_DIV4:
        count_tick = cl_tick && (presc_q & ssr_pkg::TAP_4) ==
          ssr_pkg::TAP_4;
      ssr_pkg::CS_PIN:
        count_tick = pin_rise;
      default:
        count_tick = 1'b0;
    endcase
  end

  assign overflow = count_tick && count_q == 8'hFF;
  // shared flag source chosen by the event source bit
  assign shared_set = event_source_select_q ? pin_rise : serial_done_event;
  // serial start clears it only while serial is the source
  assign shared_clr = skip_test_shared |
    (serial_start & ~event_source_select_q);
  assign timer_clr = skip_test_timer | timer_restart;

  // operating mode; reset forces run, held while reset is high
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_q <= ssr_pkg::MODE_RUN;
    else
    begin
      case (mode_q)
        ssr_pkg::MODE_RUN:
        begin
          // gate from the edge after the request pulse
          if (standby_entry && !entry_refused)
          begin
            if (stop_req)
              mode_q <= ssr_pkg::MODE_STOP;
            else
              mode_q <= ssr_pkg::MODE_HALT;
          end
        end
        ssr_pkg::MODE_HALT, ssr_pkg::MODE_STOP:
        begin
          // wake touches nothing else: state is retained
          if (any_flag)
            mode_q <= ssr_pkg::MODE_RUN;
        end
        default:
          mode_q <= ssr_pkg::MODE_RUN;
      endcase
    end
  end

  // resume pulse: core continues after the standby instruction
  always_ff @(posedge clk)
  begin
    if (rst)
      resume_q <= 1'b0;
    else
      resume_q <= wake;
  end

  // standby level seen by the core, also high during reset
  always_ff @(posedge clk)
  begin
    if (rst)
      standby_q <= 1'b1;
    else
      standby_q <= (mode_q != ssr_pkg::MODE_RUN && !any_flag) ||
        (standby_entry && !entry_refused);
  end

  // oscillator enable, dropped only in stop
  always_ff @(posedge clk)
  begin
    if (rst)
      osc_clk_en_q <= 1'b1;
    else
      osc_clk_en_q <= !(standby_entry && !entry_refused && stop_req) &&
        (mode_q != ssr_pkg::MODE_STOP || any_flag);
  end

  // divide-by-two phase, frozen while standby holds the divider
  always_ff @(posedge clk)
  begin
    if (rst)
      div2_q <= 1'b0;
    else if (mode_q == ssr_pkg::MODE_RUN)
      div2_q <= ~div2_q;
  end

  // cpu clock enable; held low in both standby modes and reset
  always_ff @(posedge clk)
  begin
    if (rst)
      cpu_clk_en_q <= 1'b0;
    else if (standby_entry && !entry_refused)
      cpu_clk_en_q <= 1'b0;
    else
      cpu_clk_en_q <= mode_q == ssr_pkg::MODE_RUN && !div2_q;
  end

  // core init: clears pc and both skip flags while high
  always_ff @(posedge clk)
  begin
    if (rst)
      core_init_q <= 1'b1;
    else
      core_init_q <= 1'b0;
  end

  // restart address; memory and other registers are not touched
  always_ff @(posedge clk)
  begin
    if (rst)
      start_addr_q <= ssr_pkg::START_ADDR;
    else
      start_addr_q <= ssr_pkg::START_ADDR;
  end

  // pin synchroniser: first stage read only by second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= external_count_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // edge history for the pin
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_prev_q <= 1'b0;
    else
      pin_prev_q <= pin_sync_q;
  end

  // prescaler chain, runs on oscillator ticks only
  always_ff @(posedge clk)
  begin
    if (rst)
      presc_q <= ssr_pkg::PRESC_RST;
    else if (cl_tick)
      presc_q <= presc_q + 8'h01;
  end

  // timer count register
  always_ff @(posedge clk)
  begin
    if (rst)
      count_q <= ssr_pkg::COUNT_RST;
    else if (timer_restart)
      count_q <= ssr_pkg::COUNT_RST;
    else if (count_tick)
      count_q <= count_q + 8'h01;
  end

  // count pulse mirrored to the timer
  always_ff @(posedge clk)
  begin
    if (rst)
      timer_count_pulse_q <= 1'b0;
    else
      timer_count_pulse_q <= count_tick;
  end

  // timer overflow flag, set wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
      timer_overflow_flag_q <= 1'b0;
    else if (overflow)
      timer_overflow_flag_q <= 1'b1;
    else if (timer_clr)
      timer_overflow_flag_q <= 1'b0;
  end

  // shared event flag, set wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
      shared_event_flag_q <= 1'b0;
    else if (shared_set)
      shared_event_flag_q <= 1'b1;
    else if (shared_clr)
      shared_event_flag_q <= 1'b0;
  end

  // clock select bits, written over the register port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clock_select_bit2_q <= 1'b0;
      clock_select_bit1_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      clock_select_bit2_q <= reg_wdata[ssr_pkg::CTRL_CS2];
      clock_select_bit1_q <= reg_wdata[ssr_pkg::CTRL_CS1];
    end
  end

  // shift mode bits; zero stops shifting and picks serial source
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shift_mode_bit2_q <= 1'b0;
      shift_mode_bit1_q <= 1'b0;
      event_source_select_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      shift_mode_bit2_q <= reg_wdata[ssr_pkg::CTRL_SM2];
      shift_mode_bit1_q <= reg_wdata[ssr_pkg::CTRL_SM1];
      event_source_select_q <= reg_wdata[ssr_pkg::CTRL_SM3];
    end
  end

  // port buffers: floated in reset, port 0 also while serial off
  generate
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
      always_ff @(posedge clk)
      begin
        if (rst)
          port_oe_n_q[p] <= 1'b1;
        else if (p == 0 && !shift_mode_bit2_q && !shift_mode_bit1_q)
          port_oe_n_q[p] <= 1'b1;
        else
          port_oe_n_q[p] <= ~port_drive_req[p];
      end
    end
  endgenerate

  // interrupt events
  assign irq_events[ssr_pkg::IRQ_WAKE] = wake;
  assign irq_events[ssr_pkg::IRQ_REFUSED] = entry_refused;
  assign irq_events[ssr_pkg::IRQ_OVF] = overflow;

  // sticky status; a read clears, a new event in that cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_stat_q <= '0;
    else if (stat_rd)
      irq_stat_q <= irq_events;
    else
      irq_stat_q <= irq_stat_q | irq_events;
  end

  // interrupt mask
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_mask_q <= ssr_pkg::MASK_RST;
    else if (reg_wr && reg_addr == ssr_pkg::OFS_IRQ_MASK)
      irq_mask_q <= reg_wdata[ssr_pkg::IRQ_W-1:0];
  end

  // level interrupt; lags the status bit by one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_stat_q & irq_mask_q);
  end

  // read data, valid only the cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        ssr_pkg::OFS_CTRL:
          reg_rdata <= {3'h0, event_source_select_q, shift_mode_bit2_q,
            shift_mode_bit1_q, clock_select_bit2_q, clock_select_bit1_q};
        ssr_pkg::OFS_STATUS:
          reg_rdata <= {4'h0, shared_event_flag_q, timer_overflow_flag_q,
            mode_q};
        ssr_pkg::OFS_IRQ_STAT:
          reg_rdata <= {5'h00, irq_stat_q};
        ssr_pkg::OFS_IRQ_MASK:
          reg_rdata <= {5'h00, irq_mask_q};
        ssr_pkg::OFS_COUNT:
          reg_rdata <= count_q;
        default:
          reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

endmodule
`default_nettype wire

// ===== test/ssr_standby_reset_assertions.sv
// assertion checker for the standby and reset controller
`default_nettype none
module ssr_sr_chk #(
  parameter int NUM_PORTS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // decoder requests
  input wire logic stop_req,
  input wire logic halt_req,
  // clock gating and core control
  input wire logic osc_clk_en_q,
  input wire logic cpu_clk_en_q,
  input wire logic core_init_q,
  input wire logic [9:0] start_addr_q,
  input wire logic resume_q,
  input wire logic standby_q,
  // request flags
  input wire logic timer_overflow_flag_q,
  input wire logic shared_event_flag_q,
  // port buffers
  input wire logic [NUM_PORTS-1:0] port_oe_n_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // any pending flag; entry must be refused while one is set
  wire logic flag_any = timer_overflow_flag_q | shared_event_flag_q;
  // either standby instruction
  wire logic req_any = stop_req | halt_req;

  // reset is watched while it is high, so no disable here
  rst_init_a: assert property (
    disable iff (1'b0) rst |=> standby_q && core_init_q && !cpu_clk_en_q
    && osc_clk_en_q && !flag_any && &port_oe_n_q)
    else $error("reset values wrong");
  start_zero_a: assert property (start_addr_q == 10'h000)
    else $error("start address not zero");
  halt_gate_a: assert property (
    halt_req && !stop_req && !standby_q && !flag_any |=>
    standby_q && !cpu_clk_en_q && osc_clk_en_q)
    else $error("halt entry wrong");
  stop_gate_a: assert property (
    stop_req && !standby_q && !flag_any |=> standby_q && !osc_clk_en_q)
    else $error("stop entry wrong");
  entry_refuse_a: assert property (
    req_any && !standby_q && flag_any |=> !standby_q)
    else $error("entry not refused");
  flag_wake_a: assert property (
    standby_q && flag_any |=> resume_q && !standby_q)
    else $error("flag did not end standby");
  cpu_hold_a: assert property (standby_q |-> !cpu_clk_en_q)
    else $error("cpu clock runs in standby");
  reset_exit_a: assert property (
    $fell(rst) |-> ##[1:2] (!standby_q && !core_init_q))
    else $error("reset release sequence wrong");
  // main scenarios
  halt_c: cover property (halt_req && !standby_q && !flag_any);
  wake_c: cover property (resume_q);
  refuse_c: cover property (req_any && flag_any && !standby_q);
endmodule

bind ssr_standby_reset ssr_sr_chk #(.NUM_PORTS(NUM_PORTS)) chk (
  .clk(clk), .rst(rst), .stop_req(stop_req), .halt_req(halt_req),
  .osc_clk_en_q(osc_clk_en_q), .cpu_clk_en_q(cpu_clk_en_q),
  .core_init_q(core_init_q), .start_addr_q(start_addr_q),
  .resume_q(resume_q), .standby_q(standby_q),
  .timer_overflow_flag_q(timer_overflow_flag_q),
  .shared_event_flag_q(shared_event_flag_q), .port_oe_n_q(port_oe_n_q));
`default_nettype wire

// ===== test/ssr_pin_model.sv
// count-pin source standing in for the outside world
`default_nettype none
module ssr_pin_model (
  // clock and enable from the bench
  input wire logic clk,
  input wire logic run,
  // pin toward the device
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_q = 2'h0; // phase of the pin waveform
  // pin rests low when idle so the first edge after run is a rise;
  // one rise in four cycles stays slow for the pin synchroniser
  always @(posedge clk)
  begin
    ph_q <= run ? ph_q + 2'h1 : 2'h0;
    pin <= run && ph_q[1];
  end
endmodule
`default_nettype wire

// ===== test/ssr_standby_reset_bench.sv
// self-checking bench for the standby and reset controller
`default_nettype none
module ssr_standby_reset_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // bench drive
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] pl = 7'h00; // stop, halt, skips, restart, serial
  logic pin_run = 1'b0;
  logic pin;
  logic [3:0] drv = 4'hF;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  int fails = 0;
  int checked = 0;
  int seed = 85578;
  // design outputs
  logic osc, cpu, init, res, sb, tf, sf, cs2, cs1, sm2, sm1, ssel, irq, tcp;
  logic [7:0] rdata, cnt;
  logic [9:0] sa;
  logic [3:0] oe;

  ssr_standby_reset dut (
    .clk(clk), .rst(rst), .stop_req(pl[0]), .halt_req(pl[1]),
    .skip_test_timer(pl[2]), .skip_test_shared(pl[3]),
    .timer_restart(pl[4]), .serial_start(pl[5]),
    .serial_done_event(pl[6]), .external_count_pin(pin),
    .port_drive_req(drv), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .osc_clk_en_q(osc),
    .cpu_clk_en_q(cpu), .timer_count_pulse_q(tcp), .core_init_q(init),
    .start_addr_q(sa), .resume_q(res), .standby_q(sb),
    .timer_overflow_flag_q(tf), .shared_event_flag_q(sf), .count_q(cnt),
    .clock_select_bit2_q(cs2), .clock_select_bit1_q(cs1),
    .shift_mode_bit2_q(sm2), .shift_mode_bit1_q(sm1),
    .event_source_select_q(ssel), .port_oe_n_q(oe), .irq_q(irq));
  ssr_pin_model pm (.clk(clk), .run(pin_run), .pin(pin));

  initial forever #4 clk = ~clk;

  // control readback keeps the five defined bits
  function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
    return d & 8'h1F;
  endfunction
  // status layout: mode, timer flag, shared flag
  function automatic logic [7:0] stat_exp(input logic [1:0] m,
    input logic t, input logic s);
    return {4'h0, s, t, m};
  endfunction
  // one comparison, counted; a miss is reported at once
  task automatic ck(input bit ok, input string m);
    checked++;
    if (!ok)
    begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // register write, strobe one cycle
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // register read; data stands only in the cycle after the strobe
  task automatic get(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    ck(rdata === e, "read data");
  endtask
  // one-cycle pulse on decoder and event lines
  task automatic pls(input logic [6:0] m);
    @(posedge clk);
    pl <= m;
    @(posedge clk);
    pl <= 7'h00;
  endtask
  // bounded wait for the wake-up pulse
  task automatic wake;
    int n;
    n = 0;
    while (res !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 2000)
    begin
      ck(1'b0, "no wake-up");
      test_done();
    end
  endtask
  // verdict and end of run
  task automatic test_done;
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    logic [7:0] d;
    logic [7:0] c0;
    logic [7:0] np;
    // drive requests held high to prove reset floats the buffers
    repeat (4) @(posedge clk);
    #1;
    ck({sb, init, cpu, osc, tf, sf, irq} === 7'h68, "reset state");
    ck({cs2, cs1, sm2, sm1, ssel} === 5'h00, "reset modes");
    ck({cnt, oe, sa} === 22'h003C00, "reset count");
    @(posedge clk);
    rst <= 1'b0;
    drv <= 4'($random(seed));
    repeat (3) @(posedge clk);
    // random control values read back
    repeat (8)
    begin
      d = 8'($random(seed));
      put(ssr_pkg::OFS_CTRL, d);
      get(ssr_pkg::OFS_CTRL, ctrl_exp(d));
    end
    for (int a = 5; a < 8; a++)
      get(3'(a), 8'h00);
    // halt with the divided timer rate and serial source
    put(ssr_pkg::OFS_CTRL, 8'h02);
    pls(7'h02);
    #1;
    ck({sb, cpu, osc} === 3'b101, "halt entry");
    // shift mode zero floats port 0, the rest follow the core
    ck(oe === {~drv[3:1], 1'b1}, "port buffers");
    get(ssr_pkg::OFS_STATUS, stat_exp(2'h1, 1'b0, 1'b0));
    c0 = cnt;
    np = 8'h00;
    // divide-by-four rate: five pulses in any twenty cycles
    repeat (20)
    begin
      @(posedge clk);
      #1;
      if (tcp === 1'b1)
        np = np + 8'h01;
    end
    ck(cnt === c0 + 8'h05, "count stalled in halt");
    ck(np === 8'h05, "count pulses in halt");
    pls(7'h40);
    wake();
    ck({sb, sf, tf} === 3'b010, "flag wake");
    get(ssr_pkg::OFS_CTRL, 8'h02);
    ck(irq === 1'b0, "masked irq");
    put(ssr_pkg::OFS_IRQ_MASK, 8'h07);
    repeat (2) @(posedge clk);
    #1;
    ck(irq === 1'b1, "unmasked irq");
    // entry with a flag still set is refused
    pls(7'h02);
    #1;
    ck(sb === 1'b0, "entry not refused");
    get(ssr_pkg::OFS_IRQ_STAT, 8'h03);
    repeat (2) @(posedge clk);
    #1;
    ck(irq === 1'b0, "irq not cleared");
    // serial start clears the flag while serial is its source
    pls(7'h20);
    #1;
    ck(sf === 1'b0, "serial start kept flag");
    // stop with the pin as count and event source
    put(ssr_pkg::OFS_CTRL, 8'h13);
    pls(7'h01);
    #1;
    ck({sb, cpu, osc} === 3'b100, "stop entry");
    get(ssr_pkg::OFS_STATUS, stat_exp(2'h2, 1'b0, 1'b0));
    @(posedge clk);
    pin_run <= 1'b1;
    wake();
    ck(sf === 1'b1, "pin wake");
    @(posedge clk);
    pin_run <= 1'b0;
    repeat (6) @(posedge clk);
    // with the pin as source a serial start must not clear the flag
    pls(7'h20);
    #1;
    ck(sf === 1'b1, "serial start cleared pin flag");
    pls(7'h08);
    #1;
    ck(sf === 1'b0, "skip test kept shared flag");
    // reset in halt: standby held until release
    put(ssr_pkg::OFS_CTRL, 8'h0E);
    pls(7'h02);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3)
    begin
      @(posedge clk);
      #1;
      ck(sb === 1'b1, "standby left in reset");
    end
    ck({cs2, cs1, sm2, sm1, ssel} === 5'h00, "modes kept");
    @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    ck({sb, init} === 2'b00, "reset release");
    // timer overflow ends halt
    put(ssr_pkg::OFS_CTRL, 8'h02);
    put(ssr_pkg::OFS_IRQ_MASK, 8'h04);
    pls(7'h10);
    pls(7'h02);
    wake();
    ck({tf, sf, irq} === 3'b101, "overflow wake");
    get(ssr_pkg::OFS_IRQ_STAT, 8'h05);
    get(ssr_pkg::OFS_CTRL, 8'h02);
    // skip test on the timer flag clears it
    pls(7'h04);
    #1;
    ck(tf === 1'b0, "skip test kept timer flag");
    test_done();
  end
endmodule
`default_nettype wire
